// *** sim/pxadc_checker.sv ***
// assertions on the ports of the conversion timing block
`timescale 1ns/1ps
module pxadc_checker (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic [7:0] addr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       conv_start_i,
   input wire logic       busy_o,
   input wire logic       recovering_o,
   input wire logic       integrating_o,
   input wire logic       led_drive_o,
   input wire logic       raw_mode_o,
   input wire logic       conv_done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_rec_res; rd_i && addr_i == 8'h0a |=> (rdata_o & 8'h8f) == 8'h00; endproperty
   a_rec_res: assert property (p_rec_res) else $error("recovery reserved bits set");
   property p_rng_res; rd_i && addr_i == 8'h0c |=> (rdata_o & 8'hdb) == 8'h00; endproperty
   a_rng_res: assert property (p_rng_res) else $error("range reserved bits set");
   property p_scl_res; rd_i && addr_i == 8'h0b |=> rdata_o[7:3] == 5'h00; endproperty
   a_scl_res: assert property (p_scl_res) else $error("scale reserved bits set");
   property p_start; conv_start_i && !busy_o |=> busy_o && recovering_o; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_rec2int; $fell(recovering_o) && busy_o |-> integrating_o; endproperty
   a_rec2int: assert property (p_rec2int) else $error("no integration after recovery");
   property p_rec_min; $rose(recovering_o) |-> recovering_o [*2]; endproperty
   a_rec_min: assert property (p_rec_min) else $error("recovery too short");
   property p_led; led_drive_o |-> integrating_o && !raw_mode_o; endproperty
   a_led: assert property (p_led) else $error("led on outside normal integration");
   property p_led_on; integrating_o && !raw_mode_o |-> led_drive_o; endproperty
   a_led_on: assert property (p_led_on) else $error("led off in normal integration");
   property p_done; conv_done_o |-> !busy_o && $past(integrating_o) ##1 !conv_done_o; endproperty
   a_done: assert property (p_done) else $error("done pulse misplaced");
endmodule : pxadc_checker

// *** sim/pxadc_host.sv ***
// host model writing and reading the setting bytes
`timescale 1ns/1ps
module pxadc_host (
   input  wire logic       clk_i,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // callers pass whole bytes, scale 0 to 7, recovery as inverse of scale
   // no channel input select reaches this block, photodiode choice stays with the host
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask : rd_reg
endmodule : pxadc_host

// *** sim/pxadc_tb.sv ***
// self-checking bench of the conversion timing block
`timescale 1ns/1ps
module pxadc_tb;
   import pxadc_pkg::*;
   logic       clk_i, resetn_i, wr_i, rd_i, conv_start_i, busy_o, recovering_o, integrating_o;
   logic       led_drive_o, high_span_o, raw_mode_o, conv_done_o;
   logic [7:0] addr_i, wdata_i, rdata_o, d, v;
   logic [2:0] scale_o;
   int         err_count, n_tests, cyc, i;
   logic [7:0] offs[3] = '{PXADC_RECOVERY_OFFS, PXADC_SCALE_OFFS, PXADC_RANGE_OFFS};
   logic [7:0] rstv[3] = '{PXADC_RECOVERY_RST, PXADC_SCALE_RST, PXADC_RANGE_RST};
   logic [7:0] msk[3]  = '{PXADC_RECOVERY_MASK, PXADC_SCALE_MASK, PXADC_RANGE_MASK};
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   pxadc_top #(.INTEG_ADC_CLOCKS(4)) pxadc_top_inst (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .conv_start_i, .busy_o, .recovering_o, .integrating_o, .led_drive_o, .high_span_o,
      .raw_mode_o, .scale_o, .conv_done_o);
   pxadc_host pxadc_host_inst (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
      .rdata_i(rdata_o));
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   function automatic int rec_clocks(input logic [2:0] c);
      return (c == 3'h0) ? 1 : (4 << c) - 1;
   endfunction : rec_clocks
   task conv(input logic [2:0] s, input logic m, input logic sp);
      int nr, ni, er, ei, k;
      logic bad;
      nr = 0; ni = 0; bad = 1'b0;
      er = rec_clocks(~s) * (PXADC_ADC_BASE_CYC << s);
      ei = 4 * (PXADC_ADC_BASE_CYC << s);
      pxadc_host_inst.wr_reg(PXADC_RECOVERY_OFFS, {1'b0, ~s, 4'h0});
      pxadc_host_inst.wr_reg(PXADC_SCALE_OFFS, {5'h00, s});
      pxadc_host_inst.wr_reg(PXADC_RANGE_OFFS, {2'b00, sp, 2'b00, m, 2'b00});
      @(posedge clk_i) conv_start_i <= 1'b1;
      for (k = 0; k < 20000 && conv_done_o !== 1'b1; k++) begin
         @(posedge clk_i) conv_start_i <= 1'b0;
         #1 nr += int'(recovering_o === 1'b1);
         ni += int'(integrating_o === 1'b1);
         if (integrating_o === 1'b1 && led_drive_o !== m) bad = 1'b1;
      end
      chk("recovery", 16'(er), (nr >= er && nr <= er + 2) ? 16'(er) : 16'(nr));
      chk("integration", 16'(ei), (ni >= ei && ni <= ei + 2) ? 16'(ei) : 16'(ni));
      chk("led", 16'h0, {15'h0, bad});
      chk("span", {15'h0, sp}, {15'h0, high_span_o});
      chk("raw", {15'h0, ~m}, {15'h0, raw_mode_o});
      chk("scale", {13'h0, s}, {13'h0, scale_o});
      $display("conversion at scale %0d done", s);
   endtask : conv
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end
   initial begin
      resetn_i = 1'b0;
      conv_start_i = 1'b0;
      void'($urandom(12));
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (i = 0; i < 3; i++) begin
         pxadc_host_inst.rd_reg(offs[i], v);
         chk("reset value", {8'h0, rstv[i]}, {8'h0, v});
      end
      repeat (4) for (i = 0; i < 3; i++) begin
         d = 8'($urandom) & msk[i];
         pxadc_host_inst.wr_reg(offs[i], d);
         pxadc_host_inst.rd_reg(offs[i], v);
         chk("readback", {8'h0, d & msk[i]}, {8'h0, v});
      end
      pxadc_host_inst.wr_reg(8'h0d, 8'hff);
      pxadc_host_inst.rd_reg(8'h0d, v);
      chk("unmapped", 16'h0000, {8'h0, v});
      $display("register test done");
      for (i = 0; i < 8; i++) conv(3'(i), 1'($urandom), 1'($urandom));
      conv(3'h5, 1'b0, 1'b1);
      results();
   end
endmodule : pxadc_tb
bind pxadc_top pxadc_checker pxadc_checker_inst (.clk_i, .resetn_i, .addr_i, .rd_i, .rdata_o, .conv_start_i,
   .busy_o, .recovering_o, .integrating_o, .led_drive_o, .raw_mode_o, .conv_done_o);

// *** src/pxadc_clkdiv.sv ***
// adc clock enable generator, period stretched by a power of two
`timescale 1ns/1ps
module pxadc_clkdiv #(
   parameter int BASE_CYC = pxadc_pkg::PXADC_ADC_BASE_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       run_i,
   input  wire logic [2:0] scale_i,
   output logic            tick_o
);
   import pxadc_pkg::*;

   localparam int DIV_W = $clog2(BASE_CYC * 128) + 1;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } pxadc_div_t;

   pxadc_div_t s_q;
   pxadc_div_t s_d;
   logic [DIV_W-1:0] last;

   // period is base cycles times 2^scale, no clamp on scale
   assign last = DIV_W'((BASE_CYC << scale_i) - 1);

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run_i) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= last) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;

endmodule : pxadc_clkdiv

// *** src/pxadc_pkg.sv ***
// constants and helpers shared by the proximity conversion timing block
package pxadc_pkg;

   // register offsets on the byte-wide register port
   localparam logic [7:0] PXADC_RECOVERY_OFFS = 8'h0a;
   localparam logic [7:0] PXADC_SCALE_OFFS    = 8'h0b;
   localparam logic [7:0] PXADC_RANGE_OFFS    = 8'h0c;

   // values after reset
   localparam logic [7:0] PXADC_RECOVERY_RST  = 8'h70;
   localparam logic [7:0] PXADC_SCALE_RST     = 8'h00;
   localparam logic [7:0] PXADC_RANGE_RST     = 8'h04;

   // writable bits; all other bits are reserved and read zero
   localparam logic [7:0] PXADC_RECOVERY_MASK = 8'h70;
   localparam logic [7:0] PXADC_SCALE_MASK    = 8'h07;
   localparam logic [7:0] PXADC_RANGE_MASK    = 8'h24;

   // field positions
   localparam int PXADC_RECOVERY_LSB = 4;
   localparam int PXADC_SCALE_LSB    = 0;
   localparam int PXADC_SPAN_BIT     = 5;
   localparam int PXADC_RAWSEL_BIT   = 2;

   // timing: one unscaled adc clock is 50 ns, system clock period 25 ns
   localparam int PXADC_CLK_PERIOD_PS = 25000;
   localparam int PXADC_ADC_CLK_NS    = 50;
   localparam int PXADC_ADC_BASE_CYC_RAW = (PXADC_ADC_CLK_NS * 1000) / PXADC_CLK_PERIOD_PS;
   localparam int PXADC_ADC_BASE_CYC  = (PXADC_ADC_BASE_CYC_RAW < 1) ? 1 : PXADC_ADC_BASE_CYC_RAW;

   // adc clocks of integration at scale zero
   localparam int PXADC_INTEG_ADC_CLOCKS = 512;

   // width of the adc clock counters
   localparam int PXADC_CNT_W = 10;

   // recovery code to adc clock count: 1, 7, 15, 31, 63, 127, 255, 511
   function automatic logic [PXADC_CNT_W-1:0] pxadc_rec_clocks(input logic [2:0] code);
      logic [PXADC_CNT_W-1:0] n;
      n = '0;
      if (code == 3'h0) begin
         n = 10'h001;
      end else begin
         n = 10'((11'h004 << code) - 11'h001);
      end
      return n;
   endfunction : pxadc_rec_clocks

endpackage : pxadc_pkg

// *** src/pxadc_top.sv ***
// proximity conversion timing configuration and measurement sequencer
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - each conversion is preceded by a recovery of 1, 7, 15, 31, 63, 127, 255 or 511 adc clocks per code 000..111.
// - each recovery adc clock lasts 50 ns times two to the power of the integration scale.
// - led pulse and integration time are stretched by two to the power of the scale field.
// - the scale divides the adc clock by 1, 2, 4 ... so 4 gives 16 and 5 gives 32.
// - the sequencer takes every scale value as written, without clamping or refusal.
// - the span bit at position 5 selects normal range at 0 and high range, gain over 14.5, at 1.
// - the select bit at position 2 gives raw adc measurement at 0 and normal proximity at 1.
// - after reset the recovery byte reads 0111 0000.
// - after reset the range and select byte reads 0000 0100.
// - in raw adc measurement the led drivers stay off and results carry no reference.
module pxadc_top #(
   parameter int INTEG_ADC_CLOCKS = pxadc_pkg::PXADC_INTEG_ADC_CLOCKS
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   input  wire logic       conv_start_i,
   output logic            busy_o,
   output logic            recovering_o,
   output logic            integrating_o,
   output logic            led_drive_o,
   output logic            high_span_o,
   output logic            raw_mode_o,
   output logic [2:0]      scale_o,
   output logic            conv_done_o
);
   import pxadc_pkg::*;

   typedef enum logic [1:0] {
      PXADC_IDLE,
      PXADC_RECOVER,
      PXADC_INTEGRATE
   } pxadc_state_t;

   typedef struct packed {
      pxadc_state_t           state;
      logic [PXADC_CNT_W-1:0] cnt;
      logic [PXADC_CNT_W-1:0] rec_len;
      logic [2:0]             scale_lat;
      logic                   raw_lat;
      logic                   span_lat;
      logic [7:0]             recovery_reg;
      logic [7:0]             scale_reg;
      logic [7:0]             range_reg;
      logic [7:0]             rdata;
      logic                   busy;
      logic                   recovering;
      logic                   integrating;
      logic                   led_drive;
      logic                   done;
   } pxadc_top_t;

   localparam logic [PXADC_CNT_W-1:0] INTEG_LAST = PXADC_CNT_W'(INTEG_ADC_CLOCKS - 1);

   pxadc_top_t s_q;
   pxadc_top_t s_d;
   logic       adc_tick;
   logic       div_run;

   // adc clock runs only while a conversion is under way
   assign div_run = (s_q.state != PXADC_IDLE);

   pxadc_clkdiv #(
      .BASE_CYC (PXADC_ADC_BASE_CYC)
   ) u_clkdiv (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .run_i    (div_run),
      .scale_i  (s_q.scale_lat),
      .tick_o   (adc_tick)
   );

   always_comb begin
      s_d       = s_q;
      s_d.rdata = 8'h00;
      s_d.done  = 1'b0;

      // register writes, reserved bits forced to zero
      if (wr_i) begin
         unique case (addr_i)
            PXADC_RECOVERY_OFFS: begin
               s_d.recovery_reg = wdata_i & PXADC_RECOVERY_MASK;
            end
            PXADC_SCALE_OFFS: begin
               s_d.scale_reg = wdata_i & PXADC_SCALE_MASK;
            end
            PXADC_RANGE_OFFS: begin
               s_d.range_reg = wdata_i & PXADC_RANGE_MASK;
            end
            default: begin
            end
         endcase
      end

      // register reads, data in the following cycle only
      if (rd_i) begin
         unique case (addr_i)
            PXADC_RECOVERY_OFFS: begin
               s_d.rdata = s_q.recovery_reg;
            end
            PXADC_SCALE_OFFS: begin
               s_d.rdata = s_q.scale_reg;
            end
            PXADC_RANGE_OFFS: begin
               s_d.rdata = s_q.range_reg;
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end

      // measurement sequencer
      unique case (s_q.state)
         PXADC_IDLE: begin
            if (conv_start_i) begin
               s_d.state      = PXADC_RECOVER;
               s_d.cnt        = '0;
               s_d.rec_len    = pxadc_rec_clocks(s_q.recovery_reg[PXADC_RECOVERY_LSB +: 3]);
               s_d.scale_lat  = s_q.scale_reg[PXADC_SCALE_LSB +: 3];
               s_d.raw_lat    = ~s_q.range_reg[PXADC_RAWSEL_BIT];
               s_d.span_lat   = s_q.range_reg[PXADC_SPAN_BIT];
               s_d.busy       = 1'b1;
               s_d.recovering = 1'b1;
            end
         end
         PXADC_RECOVER: begin
            if (adc_tick) begin
               if (s_q.cnt == s_q.rec_len - 1'b1) begin
                  // recovery over, start the stretched integration window
                  s_d.state       = PXADC_INTEGRATE;
                  s_d.cnt         = '0;
                  s_d.recovering  = 1'b0;
                  s_d.integrating = 1'b1;
                  s_d.led_drive   = ~s_q.raw_lat;
               end else begin
                  s_d.cnt = s_q.cnt + 1'b1;
               end
            end
         end
         PXADC_INTEGRATE: begin
            if (adc_tick) begin
               if (s_q.cnt == INTEG_LAST) begin
                  s_d.state       = PXADC_IDLE;
                  s_d.cnt         = '0;
                  s_d.integrating = 1'b0;
                  s_d.led_drive   = 1'b0;
                  s_d.busy        = 1'b0;
                  s_d.done        = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q              <= '0;
         s_q.state        <= PXADC_IDLE;
         s_q.recovery_reg <= PXADC_RECOVERY_RST;
         s_q.scale_reg    <= PXADC_SCALE_RST;
         s_q.range_reg    <= PXADC_RANGE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o       = s_q.rdata;
   assign busy_o        = s_q.busy;
   assign recovering_o  = s_q.recovering;
   assign integrating_o = s_q.integrating;
   assign led_drive_o   = s_q.led_drive;
   assign high_span_o   = s_q.span_lat;
   assign raw_mode_o    = s_q.raw_lat;
   assign scale_o       = s_q.scale_lat;
   assign conv_done_o   = s_q.done;

endmodule : pxadc_top
